// ### reset_supervisor_model.sv
// board reset supervisor model that watches the overflow pin
// assumes the pin idles high and is sampled on the system clock
module reset_supervisor_model (
    input  wire logic        ref_clk,           // system clock
    input  wire logic        overflow_output_n, // overflow pin from the block
    output logic      [15:0] low_width          // length of the last low pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] run_q = 16'h0000;
    initial low_width = 16'h0000;
    // the width is what this circuitry would stretch into a system reset;
    // it never feeds the block's own reset pin, which would hang the chip
    always @(posedge ref_clk) begin
        if (!overflow_output_n) begin
            run_q <= run_q + 16'h0001;
        end else if (run_q != 16'h0000) begin
            low_width <= run_q;
            run_q     <= 16'h0000;
        end
    end
endmodule : reset_supervisor_model

// ### tb_top.sv
// self-checking bench for the watchdog block and its reset supervisor
// assumes watchdog_pkg is compiled first; after time 0 drives are NBAs at posedge, or 1ns after one when they follow a wait_sig
module tb_top;
    import watchdog_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk;
    logic        reset;
    logic        mode_change_req;
    logic        standby_req;
    logic        nmi;
    bus_req_t    bus_req;
    bus_rsp_t    bus_rsp;
    logic        standby_active;
    logic        overflow_output_n;
    logic        chip_reset;
    logic        chip_reset_manual;
    logic        interval_interrupt;
    logic [15:0] low_width;
    logic [7:0]  rb;
    int          n;
    int          failures;
    int          comparisons;

    watchdog_reset_control watchdog_reset_control_inst (
        .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .mode_change_req(mode_change_req), .standby_req(standby_req), .nmi(nmi),
        .standby_active(standby_active), .overflow_output_n(overflow_output_n),
        .chip_reset(chip_reset), .chip_reset_manual(chip_reset_manual),
        .interval_interrupt(interval_interrupt));
    reset_supervisor_model reset_supervisor_model_inst (
        .ref_clk(ref_clk), .overflow_output_n(overflow_output_n), .low_width(low_width));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr_en <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr_en <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    // byte read, answer expected one cycle after the request is taken
    task automatic rc(input logic [31:0] a, input logic [7:0] exp);
        int k;
        bus_req.addr  <= a;
        bus_req.rd_en <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd_en <= 1'b0;
        k = 0;
        #1;
        while (bus_rsp.rd_valid !== 1'b1 && k < 4) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        rb = bus_rsp.rdata;
        chk({8'h00, rb}, {8'h00, exp});
        @(posedge ref_clk);
    endtask : rc

    function automatic logic pick(input int sel);
        case (sel)
            0:       return overflow_output_n;
            1:       return chip_reset;
            2:       return interval_interrupt;
            default: return standby_active;
        endcase
    endfunction : pick

    // bounded wait for a level; n returns the edges it took
    task automatic wait_sig(input int sel, input logic lvl, input int lim);
        n = 0;
        while (pick(sel) !== lvl && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({15'h0000, n >= lim}, 16'h0000);
    endtask : wait_sig

    task automatic pulse_reset();
        reset <= 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
    endtask : pulse_reset

    task automatic tally_and_finish();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_reset_values();
        rc(32'hFFFFFE80, 8'h18);
        rc(32'hFFFFFE81, 8'h00);
        rc(32'hFFFFFE83, 8'h1D);
        rc(32'hFFFFFE84, 8'h00);
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_keyed_writes();
        // slowest divider so the count cannot move while we poke it
        wr(32'hFFFFFE80, 16'hA527);
        wr(32'hFFFFFE80, 16'h5A37);
        rc(32'hFFFFFE81, 8'h37);
        wr(32'hFFFFFE80, 16'h3C11);
        rc(32'hFFFFFE81, 8'h37);
        wr(32'hFFFFFE80, 16'hA5A7);
        rc(32'hFFFFFE80, 8'h3F);
        wr(32'hFFFFFE82, 16'h5AFF);
        rc(32'hFFFFFE83, 8'h7D);
        wr(32'hFFFFFE82, 16'h5A00);
        wr(32'hFFFFFE80, 16'hA500);
        rc(32'hFFFFFE81, 8'h00);
        $display("test keyed_writes done");
    endtask : test_keyed_writes

    task automatic test_wd_timer_only();
        wr(32'hFFFFFE80, 16'hA560);
        // refresh twice before the wrap; the first refresh lands on a count-up tick
        repeat (699) @(posedge ref_clk);
        wr(32'hFFFFFE80, 16'h5A00);
        rc(32'hFFFFFE81, 8'h00);
        repeat (699) @(posedge ref_clk);
        wr(32'hFFFFFE80, 16'h5A00);
        chk({15'h0000, overflow_output_n}, 16'h0001);
        chk(low_width, 16'h0000);
        wr(32'hFFFFFE80, 16'h5AFE);
        wait_sig(0, 1'b0, 40);
        chk({15'h0000, chip_reset}, 16'h0000);
        rc(32'hFFFFFE83, 8'h9D);
        rc(32'hFFFFFE80, 8'h18);
        wait_sig(0, 1'b1, 600);
        @(posedge ref_clk);
        #1;
        chk(low_width, 16'd512);
        pulse_reset();
        rc(32'hFFFFFE83, 8'h1D);
        $display("test wd_timer_only done");
    endtask : test_wd_timer_only

    task automatic test_wd_chip_reset();
        wr(32'hFFFFFE82, 16'h5A60);
        wr(32'hFFFFFE80, 16'hA561);
        wr(32'hFFFFFE80, 16'h5AFE);
        wait_sig(0, 1'b0, 400);
        chk({15'h0000, n >= 126 && n <= 262}, 16'h0001);
        chk({14'h0000, chip_reset, chip_reset_manual}, 16'h0003);
        wait_sig(1, 1'b0, 2100);
        chk(n[15:0], 16'd2048);
        chk(low_width, 16'd512);
        rc(32'hFFFFFE83, 8'hFD);
        wr(32'hFFFFFE82, 16'hA500);
        rc(32'hFFFFFE83, 8'h7D);
        $display("test wd_chip_reset done");
    endtask : test_wd_chip_reset

    task automatic test_interval();
        wr(32'hFFFFFE80, 16'hA520);
        wr(32'hFFFFFE80, 16'h5AFE);
        wait_sig(2, 1'b1, 40);
        chk({15'h0000, overflow_output_n}, 16'h0001);
        rc(32'hFFFFFE80, 8'hB8);
        rc(32'hFFFFFE83, 8'h7D);
        wait_sig(2, 1'b0, 4);
        wait_sig(2, 1'b1, 1100);
        chk({15'h0000, n >= 1015 && n <= 1024}, 16'h0001);
        $display("test interval done");
    endtask : test_interval

    task automatic test_standby();
        mode_change_req <= 1'b1;
        @(posedge ref_clk);
        mode_change_req <= 1'b0;
        @(posedge ref_clk);
        rc(32'hFFFFFE83, 8'h1D);
        wr(32'hFFFFFE80, 16'hA520);
        standby_req <= 1'b1;
        @(posedge ref_clk);
        standby_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({15'h0000, standby_active}, 16'h0000);
        wr(32'hFFFFFE80, 16'hA500);
        rc(32'hFFFFFE81, 8'h00);
        standby_req <= 1'b1;
        @(posedge ref_clk);
        standby_req <= 1'b0;
        wait_sig(3, 1'b1, 8);
        nmi <= 1'b1;
        @(posedge ref_clk);
        nmi <= 1'b0;
        repeat (40) @(posedge ref_clk);
        rc(32'hFFFFFE81, 8'h09);
        chk({15'h0000, standby_active}, 16'h0001);
        // wake lasts 256 ticks of 4 cycles; 43 cycles are already spent above
        wait_sig(3, 1'b0, 1100);
        chk({15'h0000, n >= 970 && n <= 990}, 16'h0001);
        rc(32'hFFFFFE81, 8'h00);
        $display("test standby done");
    endtask : test_standby

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        failures = 0;
        comparisons = 0;
        reset = 1'b1;
        mode_change_req = 1'b0;
        standby_req = 1'b0;
        nmi = 1'b0;
        bus_req = '0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        test_reset_values();
        test_keyed_writes();
        test_wd_timer_only();
        test_wd_chip_reset();
        test_interval();
        test_standby();
        tally_and_finish();
    end

    // the whole run needs about 6500 cycles
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
endmodule : tb_top

// ### watchdog_consts.svh
// constants for the watchdog / interval timer block
// assumes inclusion by the design module watchdog_reset_control only
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

// ---------------------------------------------------------------
// addresses (byte addresses on the processor bus)
// ---------------------------------------------------------------
`define WD_ADDR_TIMER_WR    32'hFFFFFE80
`define WD_ADDR_CTRL_RD     32'hFFFFFE80
`define WD_ADDR_COUNT_RD    32'hFFFFFE81
`define WD_ADDR_RSTCTL_WR   32'hFFFFFE82
`define WD_ADDR_RSTCTL_RD   32'hFFFFFE83

// ---------------------------------------------------------------
// write keys
// ---------------------------------------------------------------
`define WD_KEY_COUNT        8'h5A
`define WD_KEY_CTRL         8'hA5
`define WD_KEY_RST_FLAG     8'hA5
`define WD_KEY_RST_BITS     8'h5A
`define WD_FLAG_CLR_DATA    8'h00

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define WD_BIT_FLAG         7
`define WD_BIT_MODE         6
`define WD_BIT_ENABLE       5
`define WD_BIT_INTERNAL_RESET_ENABLE         6
`define WD_BIT_RESET_TYPE_SELECT         5
`define WD_RSTCTL_RESET     8'h1D
`define WD_RSTCTL_RSVD      5'h1D
`define WD_CTRL_RSVD        2'h3
`define WD_CTRL_RESET       8'h18

// ---------------------------------------------------------------
// pulse widths in system clock cycles
// ---------------------------------------------------------------
`define WD_OVF_PULSE_CYC    512
`define WD_RST_PULSE_CYC    2048

`endif

// ### watchdog_pkg.sv
// types shared by the watchdog block
// assumes watchdog_consts.svh is reachable on the include path
package watchdog_pkg;
    typedef struct packed {
        logic        wr_en;   // one-cycle word write
        logic [31:0] addr;    // byte address
        logic [15:0] wdata;   // word data
        logic        rd_en;   // one-cycle byte read
    } bus_req_t;

    typedef struct packed {
        logic       rd_valid;
        logic [7:0] rdata;
    } bus_rsp_t;

    typedef enum logic [1:0] {
        RUN_IDLE    = 2'b00,
        RUN_COUNT   = 2'b01,
        RUN_STANDBY = 2'b10,
        RUN_WAKE    = 2'b11
    } run_state_t;
endpackage : watchdog_pkg

// ### watchdog_reset_control.sv
// watchdog / interval timer with keyed register writes and reset generation
// assumes a processor bus giving one-cycle word writes and byte reads
// Overview of operation
// - reset control loads 1D except overflow reset
// - flag set on wrap only in watchdog mode
// - bit6 chooses chip reset or timer-only reset
// - bit5 selects power-on or manual reset
// - reserved bits read 1,1,1,0,1
// - shared write address, keys 5A count, A5 control
// - A5 00 word clears overflow flag only
// - 5A word copies bits 6,5 only
// - byte reads at base, base+1, base+3
// - overflow pin low for 512 cycles
// - internal reset held 2048 cycles
// - external reset wins and clears flag
// - interval overflow sets flag and interrupt
// - refuse standby while counting is enabled
// - wake counts from NMI, ends on wrap
// - write beats simultaneous increment
// - counts when enabled; disable clears counter
// - divider code picks 4 to 16384
`include "watchdog_consts.svh"
module watchdog_reset_control (
    input  wire logic                 ref_clk,           // system clock
    input  wire logic                 reset,             // external reset pin, active high
    input  wire watchdog_pkg::bus_req_t bus_req,         // processor bus request
    output watchdog_pkg::bus_rsp_t    bus_rsp,           // read answer, one cycle later
    input  wire logic                 mode_change_req,   // standby/clock change/pause entry
    input  wire logic                 standby_req,       // request to enter standby
    input  wire logic                 nmi,               // wake request in standby
    output logic                      standby_active,    // chip held in standby
    output logic                      overflow_output_n, // overflow pin, active low
    output logic                      chip_reset,        // internal chip reset
    output logic                      chip_reset_manual, // 1 manual, 0 power-on type
    output logic                      interval_interrupt // interval timer request
);
    import watchdog_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  count_register;
        logic        interval_overflow_flag;
        logic        timer_mode_select;
        logic        count_enable;
        logic [2:0]  clock_divider_select;
        logic        watchdog_overflow_flag;
        logic        internal_reset_enable;
        logic        reset_type_select;
        run_state_t  run;
        logic [8:0]  ovf_cnt;
        logic        ovf_act;
        logic [10:0] rst_cnt;
        logic        rst_act;
        logic        rst_manual;
        logic        rsp_valid;
        logic [7:0]  rsp_data;
        logic        irq;
        logic        stby;
        logic [9:0]  low_seen;
        logic [11:0] rst_seen;
    } wd_state_t;

    wd_state_t s_q;
    wd_state_t s_d;
    logic      tick;
    logic      counting;
    logic      wr_timer;
    logic      wr_rst;
    logic      wr_count;
    logic      wr_ctrl;
    logic      wrap;
    logic [7:0] ctrl_view;
    logic [7:0] rst_view;

    assign counting = (s_q.run == RUN_COUNT) || (s_q.run == RUN_WAKE);

    wd_prescaler #(
        .WIDTH (14)
    ) u_pre (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (counting),
        .sel     (s_q.clock_divider_select),
        .tick    (tick)
    );

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    assign wr_timer = bus_req.wr_en && (bus_req.addr == `WD_ADDR_TIMER_WR);
    assign wr_rst   = bus_req.wr_en && (bus_req.addr == `WD_ADDR_RSTCTL_WR);
    assign wr_count = wr_timer && (bus_req.wdata[15:8] == `WD_KEY_COUNT);
    assign wr_ctrl  = wr_timer && (bus_req.wdata[15:8] == `WD_KEY_CTRL);
    // a counter write in the same cycle as the tick suppresses the wrap
    assign wrap     = tick && counting && !wr_count && (s_q.count_register == 8'hFF);

    assign ctrl_view = {s_q.interval_overflow_flag, s_q.timer_mode_select, s_q.count_enable,
                        `WD_CTRL_RSVD, s_q.clock_divider_select};
    assign rst_view  = {s_q.watchdog_overflow_flag, s_q.internal_reset_enable,
                        s_q.reset_type_select, `WD_RSTCTL_RSVD};

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.irq       = 1'b0;

        // byte reads, one cycle latency
        if (bus_req.rd_en) begin
            s_d.rsp_valid = 1'b1;
            case (bus_req.addr)
                `WD_ADDR_CTRL_RD:   s_d.rsp_data = ctrl_view;
                `WD_ADDR_COUNT_RD:  s_d.rsp_data = s_q.count_register;
                `WD_ADDR_RSTCTL_RD: s_d.rsp_data = rst_view;
                default:            s_d.rsp_data = 8'h00;
            endcase
        end

        // counter: write wins over increment
        if (wr_count) begin
            s_d.count_register = bus_req.wdata[7:0];
        end else if (tick && counting) begin
            s_d.count_register = s_q.count_register + 8'h01;
        end

        if (wr_ctrl) begin
            // flag bit only accepts 0
            if (!bus_req.wdata[`WD_BIT_FLAG]) begin
                s_d.interval_overflow_flag = 1'b0;
            end
            s_d.timer_mode_select    = bus_req.wdata[`WD_BIT_MODE];
            s_d.count_enable         = bus_req.wdata[`WD_BIT_ENABLE];
            s_d.clock_divider_select = bus_req.wdata[2:0];
        end

        if (wr_rst && bus_req.wdata[15:8] == `WD_KEY_RST_FLAG
            && bus_req.wdata[7:0] == `WD_FLAG_CLR_DATA) begin
            s_d.watchdog_overflow_flag = 1'b0;
        end
        if (wr_rst && bus_req.wdata[15:8] == `WD_KEY_RST_BITS) begin
            s_d.internal_reset_enable = bus_req.wdata[`WD_BIT_INTERNAL_RESET_ENABLE];
            s_d.reset_type_select     = bus_req.wdata[`WD_BIT_RESET_TYPE_SELECT];
        end

        // run state
        case (s_q.run)
            RUN_IDLE: begin
                if (standby_req && !s_q.count_enable) begin
                    s_d.run = RUN_STANDBY;
                end else if (s_d.count_enable) begin
                    s_d.run = RUN_COUNT;
                end
            end
            RUN_COUNT: begin
                if (!s_d.count_enable) begin
                    s_d.run = RUN_IDLE;
                end
            end
            RUN_STANDBY: begin
                if (nmi) begin
                    s_d.run = RUN_WAKE;
                end
            end
            RUN_WAKE: begin
                if (wrap) begin
                    s_d.run = RUN_IDLE;
                end
            end
            default: s_d.run = RUN_IDLE;
        endcase

        // overflow handling; set after clear so the event wins
        if (wrap && s_q.run == RUN_COUNT) begin
            if (s_q.timer_mode_select) begin
                s_d.watchdog_overflow_flag = 1'b1;
                s_d.ovf_act = 1'b1;
                s_d.ovf_cnt = 9'h000;
                if (s_q.internal_reset_enable) begin
                    s_d.rst_act    = 1'b1;
                    s_d.rst_cnt    = 11'h000;
                    s_d.rst_manual = s_q.reset_type_select;
                end else begin
                    // timer-only reset: counter and control back to defaults
                    s_d.count_register         = 8'h00;
                    s_d.interval_overflow_flag = 1'b0;
                    s_d.timer_mode_select      = 1'b0;
                    s_d.count_enable           = 1'b0;
                    s_d.clock_divider_select   = 3'h0;
                    s_d.run                    = RUN_IDLE;
                end
            end else begin
                s_d.interval_overflow_flag = 1'b1;
                s_d.irq                    = 1'b1;
            end
        end

        if (!s_d.count_enable && s_q.run != RUN_STANDBY && s_q.run != RUN_WAKE) begin
            s_d.count_register = 8'h00;
        end

        if (s_q.ovf_act) begin
            s_d.ovf_cnt = s_q.ovf_cnt + 9'h001;
            if (s_q.ovf_cnt == 9'(`WD_OVF_PULSE_CYC - 1)) begin
                s_d.ovf_act = 1'b0;
            end
        end
        if (s_q.rst_act) begin
            s_d.rst_cnt = s_q.rst_cnt + 11'h001;
            if (s_q.rst_cnt == 11'(`WD_RST_PULSE_CYC - 1)) begin
                s_d.rst_act = 1'b0;
            end
            // internal reset clears timer but not reset control
            s_d.count_register       = 8'h00;
            s_d.timer_mode_select    = 1'b0;
            s_d.count_enable         = 1'b0;
            s_d.interval_overflow_flag = 1'b0;
            s_d.clock_divider_select = 3'h0;
            s_d.run                  = RUN_IDLE;
        end

        // standby, clock change, pause: reset control reloads, low ctrl bits kept
        if (mode_change_req) begin
            s_d.watchdog_overflow_flag = 1'b0;
            s_d.internal_reset_enable  = 1'b0;
            s_d.reset_type_select      = 1'b0;
            s_d.interval_overflow_flag = 1'b0;
            s_d.timer_mode_select      = 1'b0;
            s_d.count_enable           = 1'b0;
        end

        // the chip stays in standby until the wake count wraps
        s_d.stby = (s_d.run == RUN_STANDBY) || (s_d.run == RUN_WAKE);
        // observation counters for the pulse-width checks; no logic reads them
        s_d.low_seen = overflow_output_n ? 10'h000 : s_q.low_seen + 10'h001;
        s_d.rst_seen = chip_reset ? s_q.rst_seen + 12'h001 : 12'h000;
    end

    // ---------------------------------------------------------------
    // registers; external reset wins over any overflow and clears flags
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_rsp.rd_valid   = s_q.rsp_valid;
    assign bus_rsp.rdata      = s_q.rsp_data;
    assign overflow_output_n  = !s_q.ovf_act;
    assign chip_reset         = s_q.rst_act;
    assign chip_reset_manual  = s_q.rst_manual;
    assign interval_interrupt = s_q.irq;
    assign standby_active     = s_q.stby;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_flag_wd_only: assert property (wrap && s_q.run == RUN_COUNT && !s_q.timer_mode_select
        |=> $stable(s_q.watchdog_overflow_flag)) else $error("flag set in interval mode");
    a_pin_low_on_ovf: assert property (wrap && s_q.run == RUN_COUNT && s_q.timer_mode_select
        |=> !overflow_output_n) else $error("overflow pin not driven");
    a_pin_width_max: assert property (!overflow_output_n |-> s_q.low_seen < 10'(`WD_OVF_PULSE_CYC))
        else $error("overflow pin low too long");
    a_pin_width_min: assert property ($rose(overflow_output_n) |-> s_q.low_seen == 10'(`WD_OVF_PULSE_CYC))
        else $error("overflow pin low too short");
    a_rst_width_max: assert property (chip_reset |-> s_q.rst_seen < 12'(`WD_RST_PULSE_CYC))
        else $error("internal reset held too long");
    a_rst_width_min: assert property ($fell(chip_reset) |-> s_q.rst_seen == 12'(`WD_RST_PULSE_CYC))
        else $error("internal reset too short");
    a_rst_needs_en: assert property ($rose(chip_reset) |-> $past(s_q.internal_reset_enable))
        else $error("reset without enable");
    a_rst_type: assert property ($rose(chip_reset) |-> chip_reset_manual == $past(s_q.reset_type_select))
        else $error("reset type mismatch");
    a_key_clear: assert property (wr_rst && bus_req.wdata == 16'hA500 && !wrap
        |=> !s_q.watchdog_overflow_flag && $stable(s_q.internal_reset_enable)) else $error("flag clear failed");
    a_key_bits: assert property (wr_rst && bus_req.wdata[15:8] == 8'h5A && !mode_change_req
        |=> s_q.internal_reset_enable == $past(bus_req.wdata[6])) else $error("enable bit not copied");
    a_write_wins: assert property (wr_count && tick && s_q.count_enable && !s_q.rst_act && !mode_change_req
        && !wrap |=> s_q.count_register == $past(bus_req.wdata[7:0])) else $error("write lost to increment");
    a_no_standby_run: assert property (standby_req && s_q.count_enable && !standby_active
        |=> !standby_active) else $error("standby while enabled");
    a_interval_irq: assert property (wrap && s_q.run == RUN_COUNT && !s_q.timer_mode_select
        |=> interval_interrupt && s_q.interval_overflow_flag) else $error("interval irq missing");
    a_rsvd_read: assert property (bus_req.rd_en && bus_req.addr == 32'hFFFFFE83
        |=> bus_rsp.rdata[4:0] == 5'h1D) else $error("reserved bits wrong");

    c_wd_overflow: cover property ($fell(overflow_output_n));
    c_chip_reset:  cover property ($rose(chip_reset));
    c_interval:    cover property (interval_interrupt);
    c_wake:        cover property (s_q.run == RUN_WAKE ##1 s_q.run == RUN_IDLE);
endmodule : watchdog_reset_control

// ### wd_prescaler.sv
// prescaler, cleared while run is low, producing the selected count-up tick
// assumes one system clock; tick is one cycle wide
module wd_prescaler #(
    parameter int WIDTH = 14
) (
    input  wire logic       ref_clk, // system clock
    input  wire logic       reset,   // async, active high
    input  wire logic       run,     // count while high
    input  wire logic [2:0] sel,     // divider code
    output logic            tick     // registered count pulse
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             tick;
    } pre_state_t;

    pre_state_t s_q;
    pre_state_t s_d;
    logic [WIDTH-1:0] mask;

    always_comb begin
        case (sel)
            3'h0:    mask = 14'h0003;
            3'h1:    mask = 14'h007F;
            3'h2:    mask = 14'h00FF;
            3'h3:    mask = 14'h01FF;
            3'h4:    mask = 14'h03FF;
            3'h5:    mask = 14'h07FF;
            3'h6:    mask = 14'h1FFF;
            default: mask = 14'h3FFF;
        endcase
        s_d = s_q;
        if (!run) begin
            s_d.cnt  = '0;
            s_d.tick = 1'b0;
        end else begin
            s_d.cnt  = s_q.cnt + 1'b1;
            s_d.tick = ((s_q.cnt & mask) == mask);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : wd_prescaler
